// file: verilog/tsc_defines.vh
// How it works
// - no trigger action until system armed
// - abort idles both systems, stops output, measurement
// - abort also ends any list or pulse
// - arm moves idle system to awaiting event
// - arm ignored unless system is idle
// - both armed: measurement takes first event
// - auto_rearm 1 re-arms transient; 0 default
// - immediate transient fires on arm; default
// - bus source fires on bus trigger after arm
// - external source fires on external pulse
// - sync repeat: all repetitions or first only
// - measure sources: immediate, phase, bus, trigger-out
// - immediate measurement acquires at once, flags results
// - sync start: immediate or at phase angle
// - start phase -360..+360, reset zero
// - state query: idle, armed, busy, awaiting
// - state updates when last list point executes
`ifndef TSC_DEFINES_VH
`define TSC_DEFINES_VH
// register byte offsets
`define TSC_REG_CMD 8'h00
`define TSC_REG_CFG 8'h04
`define TSC_REG_PHASE 8'h08
`define TSC_REG_STATUS 8'h0C
// command register bits (write one to act)
`define TSC_CMD_ABORT 0
`define TSC_CMD_ARM_TRAN 1
`define TSC_CMD_ARM_MEAS 2
`define TSC_CMD_BUS_TRIG 3
// config register fields
`define TSC_CFG_REARM 0
`define TSC_CFG_TSEL_LO 1
`define TSC_CFG_SREP 3
`define TSC_CFG_MSEL_LO 4
`define TSC_CFG_SSTART 6
`define TSC_CFG_RESET 7'h00
// transient trigger sources
`define TSC_TSRC_IMM 2'h0
`define TSC_TSRC_BUS 2'h1
`define TSC_TSRC_PIN 2'h2
// measurement trigger sources
`define TSC_MSRC_IMM 2'h0
`define TSC_MSRC_PHASE 2'h1
`define TSC_MSRC_BUS 2'h2
`define TSC_MSRC_TOUT 2'h3
// reported state codes
`define TSC_ST_IDLE 2'h0
`define TSC_ST_ARM 2'h1
`define TSC_ST_BUSY 2'h2
`define TSC_ST_AWAIT 2'h3
// phase limits in degrees
`define TSC_PHASE_MAX 10'sh168
`define TSC_PHASE_MIN -10'sh168
`define TSC_PHASE_FULL 10'h168
`define TSC_PHASE_RESET 10'h000
`endif

// file: verilog/tsc_trigger.v
`timescale 1ns/100ps
`include "tsc_defines.vh"
module tsc_trigger
(
  // clock, reset, enable
  input wire pclk,
  input wire presetn,
  input wire ce,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // pins and phase reference
  input wire external_input,
  input wire [8:0] ref_phase,
  output reg trigger_out_signal,
  // transient sequencer
  output reg tran_start,
  output reg tran_abort,
  output reg rep_go,
  input wire rep_req,
  input wire last_point_done,
  // measurement engine
  output reg acq_start,
  output reg acq_abort,
  input wire acq_done
);

  // one-hot states
  localparam S_IDLE = 4'b0001;
  localparam S_AWAIT = 4'b0010;
  localparam S_ARM = 4'b0100;
  localparam S_BUSY = 4'b1000;

  // settings
  reg auto_rearm;
  reg [1:0] transient_trigger_select;
  reg sync_repeat_select;
  reg [1:0] measure_trigger_select;
  reg sync_start_select;
  reg signed [9:0] start_phase_angle;
  // state
  reg [3:0] tran_state;
  reg [3:0] meas_state;
  reg results_ready;
  reg rep_wait;
  reg first_rep;
  reg pin_s1;
  reg pin_s2;
  reg pin_d;
  // strobes
  wire acc;
  wire wr;
  wire rd;
  wire cmd_wr;
  wire do_abort;
  wire do_arm_t;
  wire do_arm_m;
  wire bus_trig;
  wire pin_pulse;
  wire phase_hit;
  wire meas_fire;
  wire tran_fire;
  wire tran_event;
  wire rep_sync;
  reg [3:0] next_tran_state;
  reg [3:0] next_meas_state;
  reg [31:0] rd_mux;
  reg rd_err;

  // clamp a written angle into range
  function signed [9:0] clamp_angle;
    input [31:0] v;
    reg signed [31:0] s;
    begin
      s = v;
      if (s > 360)
        clamp_angle = `TSC_PHASE_MAX;
      else if (s < -360)
        clamp_angle = `TSC_PHASE_MIN;
      else
        clamp_angle = s[9:0];
    end
  endfunction

  // map angle onto 0..359 for comparison
  function [8:0] norm_angle;
    input signed [9:0] a;
    reg [9:0] u;
    begin
      if (a < 0)
        u = a + `TSC_PHASE_FULL;
      else
        u = a;
      if (u == `TSC_PHASE_FULL)
        u = 10'h000;
      norm_angle = u[8:0];
    end
  endfunction

  // encode a one-hot state for the state query
  function [1:0] state_code;
    input [3:0] st;
    begin
      case (st)
        S_AWAIT: state_code = `TSC_ST_AWAIT;
        S_ARM: state_code = `TSC_ST_ARM;
        S_BUSY: state_code = `TSC_ST_BUSY;
        default: state_code = `TSC_ST_IDLE;
      endcase
    end
  endfunction

  // bus strobes: writes act at the edge where pready is high, reads latch one edge earlier
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign rd = psel & penable & ~pready & ~pwrite;
  assign cmd_wr = wr & (paddr == `TSC_REG_CMD);
  assign do_abort = cmd_wr & pwdata[`TSC_CMD_ABORT];
  assign do_arm_t = cmd_wr & pwdata[`TSC_CMD_ARM_TRAN] & ~do_abort;
  assign do_arm_m = cmd_wr & pwdata[`TSC_CMD_ARM_MEAS] & ~do_abort;
  assign bus_trig = cmd_wr & pwdata[`TSC_CMD_BUS_TRIG] & ~do_abort;
  // rising edge of synchronised external input
  assign pin_pulse = pin_s2 & ~pin_d;
  assign phase_hit = (ref_phase == norm_angle(start_phase_angle));

  // measurement trigger, only from awaiting
  assign meas_fire = (meas_state == S_AWAIT) & ~do_abort &
    ((measure_trigger_select == `TSC_MSRC_IMM) |
     ((measure_trigger_select == `TSC_MSRC_PHASE) & phase_hit) |
     ((measure_trigger_select == `TSC_MSRC_BUS) & bus_trig) |
     ((measure_trigger_select == `TSC_MSRC_TOUT) & trigger_out_signal));

  // transient event sources
  assign tran_event = (transient_trigger_select == `TSC_TSRC_IMM) |
    ((transient_trigger_select == `TSC_TSRC_BUS) & bus_trig) |
    ((transient_trigger_select == `TSC_TSRC_PIN) & pin_pulse);
  // measurement has priority on a shared event
  assign tran_fire = (tran_state == S_AWAIT) & ~do_abort & tran_event & ~meas_fire;
  // repetition needs phase alignment
  assign rep_sync = sync_start_select & (sync_repeat_select | first_rep);

  // transient next state
  always @*
  begin
    next_tran_state = tran_state;
    case (tran_state)
      S_IDLE:
        if (do_arm_t)
          next_tran_state = S_AWAIT;
      S_AWAIT:
        if (tran_fire)
          next_tran_state = sync_start_select ? S_ARM : S_BUSY;
      S_ARM:
        if (phase_hit)
          next_tran_state = S_BUSY;
      S_BUSY:
        if (last_point_done)
          next_tran_state = auto_rearm ? S_AWAIT : S_IDLE;
      default:
        next_tran_state = S_IDLE;
    endcase
    if (do_abort)
      next_tran_state = S_IDLE;
  end

  // measurement next state
  always @*
  begin
    next_meas_state = meas_state;
    case (meas_state)
      S_IDLE:
        if (do_arm_m)
          next_meas_state = S_AWAIT;
      S_AWAIT:
        if (meas_fire)
          next_meas_state = S_BUSY;
      S_BUSY:
        if (acq_done)
          next_meas_state = S_IDLE;
      default:
        next_meas_state = S_IDLE;
    endcase
    if (do_abort)
      next_meas_state = S_IDLE;
  end

  // read mux
  always @*
  begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    case (paddr)
      `TSC_REG_CMD:
        rd_mux = 32'h00000000;
      `TSC_REG_CFG:
        rd_mux = {25'h0000000, sync_start_select, measure_trigger_select, sync_repeat_select,
          transient_trigger_select, auto_rearm};
      `TSC_REG_PHASE:
        rd_mux = {{22{start_phase_angle[9]}}, start_phase_angle};
      `TSC_REG_STATUS:
        rd_mux = {27'h0000000, results_ready, state_code(meas_state), state_code(tran_state)};
      default:
        rd_err = 1'b1;
    endcase
  end

  // apb handshake: one wait cycle per access
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & rd_err;
      if (rd)
        prdata <= rd_mux;
    end
  end

  // settings registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {sync_start_select, measure_trigger_select, sync_repeat_select,
        transient_trigger_select, auto_rearm} <= `TSC_CFG_RESET;
      start_phase_angle <= `TSC_PHASE_RESET;
    end
    else if (ce & wr)
    begin
      if (paddr == `TSC_REG_CFG)
      begin
        auto_rearm <= pwdata[`TSC_CFG_REARM];
        transient_trigger_select <= pwdata[`TSC_CFG_TSEL_LO +: 2];
        sync_repeat_select <= pwdata[`TSC_CFG_SREP];
        measure_trigger_select <= pwdata[`TSC_CFG_MSEL_LO +: 2];
        sync_start_select <= pwdata[`TSC_CFG_SSTART];
      end
      if (paddr == `TSC_REG_PHASE)
        start_phase_angle <= clamp_angle(pwdata);
    end
  end

  // external input synchroniser
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_d <= 1'b0;
    end
    else if (ce)
    begin
      pin_s1 <= external_input;
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  // state machines and output strobes
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tran_state <= S_IDLE;
      meas_state <= S_IDLE;
      tran_start <= 1'b0;
      tran_abort <= 1'b0;
      acq_start <= 1'b0;
      acq_abort <= 1'b0;
      trigger_out_signal <= 1'b0;
      rep_go <= 1'b0;
      rep_wait <= 1'b0;
      first_rep <= 1'b0;
      results_ready <= 1'b0;
    end
    else if (ce)
    begin
      tran_state <= next_tran_state;
      meas_state <= next_meas_state;
      // transient begins on entry to busy
      tran_start <= (next_tran_state == S_BUSY) & (tran_state != S_BUSY);
      trigger_out_signal <= tran_fire;
      acq_start <= meas_fire;
      // abort pulses stop output, lists and measurement
      tran_abort <= do_abort;
      acq_abort <= do_abort;
      // repetitions after the first, aligned if selected
      rep_go <= 1'b0;
      if (tran_start)
        first_rep <= 1'b0;
      else if (tran_fire)
        first_rep <= 1'b1;
      if (do_abort | (tran_state != S_BUSY))
        rep_wait <= 1'b0;
      else if (rep_wait & phase_hit)
      begin
        rep_wait <= 1'b0;
        rep_go <= 1'b1;
      end
      else if (rep_req)
      begin
        if (rep_sync)
          rep_wait <= 1'b1;
        else
          rep_go <= 1'b1;
      end
      // results available once the set is complete
      if (do_abort | do_arm_m & (meas_state == S_IDLE))
        results_ready <= 1'b0;
      else if (acq_done & (meas_state == S_BUSY))
        results_ready <= 1'b1;
    end
  end

endmodule

// file: sim/tsc_seq_model.sv
`timescale 1ns/100ps
module tsc_seq_model
(
  // clock and reset
  input wire pclk,
  input wire presetn,
  // run length of a list or acquisition
  input wire [4:0] lat,
  // requests from the block
  input wire tran_start,
  input wire tran_abort,
  input wire acq_start,
  input wire acq_abort,
  // answers to the block
  output reg rep_req,
  output reg last_point_done,
  output reg acq_done
);
  reg [4:0] tc; // list cycles left
  reg [4:0] mc; // acquisition cycles left
  // sequencer and measurement engine, answers are one-cycle pulses
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tc <= 5'h00;
      mc <= 5'h00;
      rep_req <= 1'b0;
      last_point_done <= 1'b0;
      acq_done <= 1'b0;
    end
    else
    begin
      rep_req <= (tc == 5'h03);
      last_point_done <= (tc == 5'h01); // one-cycle pulse as the list count reaches zero
      acq_done <= (mc == 5'h01);
      tc <= tran_abort ? 5'h00 : tran_start ? lat : (tc != 5'h00) ? tc - 5'h01 : tc;
      mc <= acq_abort ? 5'h00 : acq_start ? lat : (mc != 5'h00) ? mc - 5'h01 : mc;
    end
  end
endmodule

// file: sim/tsc_trigger_checker.sv
`timescale 1ns/100ps
module tsc_checker
(
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // trigger outputs
  input wire trigger_out_signal,
  input wire tran_start,
  input wire tran_abort,
  input wire acq_start
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_answer: assert property ($rose(penable) && psel |-> ##[1:2] pready) else $error("apb answer late");
  a_ready_single: assert property (pready |=> !pready) else $error("pready held");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_tout_pulse: assert property (trigger_out_signal |=> !trigger_out_signal) else $error("trigger out held");
  a_start_pulse: assert property (tran_start |=> !tran_start) else $error("start held");
  a_start_no_abort: assert property (tran_start |-> !tran_abort) else $error("start with abort");
  a_abort_quiet: assert property (tran_abort |=> !tran_start) else $error("start after abort");
  a_acq_pulse: assert property (acq_start |=> !acq_start) else $error("acq start held");
  a_quiet_reset: assert property ($rose(presetn) |-> !tran_start && !acq_start) else $error("action unarmed");
  c_start: cover property (tran_start);
  c_acq: cover property (acq_start);
  c_err: cover property (pslverr);
endmodule
bind tsc_trigger tsc_checker u_tsc_checker (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .trigger_out_signal, .tran_start, .tran_abort, .acq_start);

// file: sim/test_tsc_trigger.sv
`timescale 1ns/100ps
`include "tsc_defines.vh"
module test_tsc_trigger;
  localparam [7:0] cmd = `TSC_REG_CMD;
  localparam [7:0] cfg = `TSC_REG_CFG;
  localparam [7:0] phs = `TSC_REG_PHASE;
  localparam [7:0] sts = `TSC_REG_STATUS;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg external_input = 1'b0;
  reg [8:0] ref_phase = 9'h000;
  reg [4:0] lat = 5'h14;
  wire [31:0] prdata;
  wire pready, pslverr, trigger_out_signal, tran_start, tran_abort, rep_go;
  wire rep_req, last_point_done, acq_start, acq_abort, acq_done;
  integer n_errors = 0;
  integer checked = 0;
  integer n_ts = 0; // transient starts seen
  integer n_ta = 0; // transient aborts seen
  integer n_rg = 0; // repetition grants seen
  integer n_to = 0; // trigger out pulses seen
  integer n_aa = 0; // measurement aborts seen
  integer seed = 32'haa5e;
  integer i, v;
  reg [31:0] rd;
  reg er;
  tsc_trigger u_tsc_trigger (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .external_input, .ref_phase, .trigger_out_signal, .tran_start, .tran_abort,
    .rep_go, .rep_req, .last_point_done, .acq_start, .acq_abort, .acq_done);
  tsc_seq_model u_tsc_seq_model (.pclk, .presetn, .lat, .tran_start, .tran_abort, .acq_start,
    .acq_abort, .rep_req, .last_point_done, .acq_done);
  // clock
  initial forever #2 pclk = ~pclk;
  // count output pulses
  always @(posedge pclk)
  begin
    if (tran_start === 1'b1) n_ts <= n_ts + 1;
    if (tran_abort === 1'b1) n_ta <= n_ta + 1;
    if (rep_go === 1'b1) n_rg <= n_rg + 1;
    if (trigger_out_signal === 1'b1) n_to <= n_to + 1;
    if (acq_abort === 1'b1) n_aa <= n_aa + 1;
  end
  // one apb transfer, held until pready
  task apb(input [7:0] a, input w, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task chk(input [31:0] e, input [31:0] g, input string nm);
    begin
      checked += 1;
      if (g !== e)
      begin
        n_errors += 1;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task rs(input [31:0] e);
    begin
      apb(sts, 1'b0, 32'h0);
      chk(e, rd, "status");
    end
  endtask
  function [31:0] clampf(input integer x);
    clampf = x > 360 ? 360 : (x < -360 ? -360 : x);
  endfunction
  task print_verdict;
    begin
      $display("checked %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // watchdog
  initial
  begin
    #40000;
    n_errors += 1;
    print_verdict;
  end
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(cfg, 1'b0, 32'h0);
    chk(`TSC_CFG_RESET, rd, "cfg");
    apb(phs, 1'b0, 32'h0);
    chk(0, rd, "phase");
    rs(0);
    chk(0, n_ts, "starts");
    $display("test reset done");
    apb(cmd, 1'b1, 32'h2);
    apb(cmd, 1'b1, 32'h2);
    repeat (40) @(posedge pclk);
    rs(0);
    chk(1, n_ts, "starts");
    $display("test immediate done");
    apb(cfg, 1'b1, 32'h3);
    lat <= 5'h05;
    apb(cmd, 1'b1, 32'h2);
    rs(3);
    apb(cmd, 1'b1, 32'h8);
    repeat (20) @(posedge pclk);
    rs(3);
    lat <= 5'h14;
    apb(cmd, 1'b1, 32'h8);
    apb(cmd, 1'b1, 32'h1);
    rs(0);
    chk(1, n_ta != 0, "abort");
    chk(3, n_ts, "starts");
    $display("test bus rearm done");
    apb(cfg, 1'b1, 32'h22);
    lat <= 5'h04;
    apb(cmd, 1'b1, 32'h4);
    apb(cmd, 1'b1, 32'h2);
    rs(32'hF);
    apb(cmd, 1'b1, 32'h8);
    repeat (20) @(posedge pclk);
    rs(32'h13);
    apb(cmd, 1'b1, 32'h8);
    repeat (20) @(posedge pclk);
    chk(4, n_ts, "starts");
    rs(32'h10);
    $display("test priority done");
    apb(cfg, 1'b1, 32'h4);
    apb(cmd, 1'b1, 32'h2);
    rs(32'h13);
    external_input <= 1'b1;
    repeat (3) @(posedge pclk);
    external_input <= 1'b0;
    repeat (30) @(posedge pclk);
    chk(5, n_ts, "starts");
    $display("test external done");
    apb(phs, 1'b1, 32'd90);
    apb(cfg, 1'b1, 32'h48);
    apb(cmd, 1'b1, 32'h2);
    rs(32'h11);
    chk(5, n_ts, "starts");
    ref_phase <= 9'd90;
    repeat (30) @(posedge pclk);
    chk(6, n_ts, "starts");
    $display("test phase done");
    apb(cfg, 1'b1, 32'h0);
    apb(cmd, 1'b1, 32'h1);
    rs(0);
    apb(cmd, 1'b1, 32'h4);
    repeat (20) @(posedge pclk);
    rs(32'h10);
    ref_phase <= 9'd0;
    apb(cfg, 1'b1, 32'h10);
    apb(cmd, 1'b1, 32'h4);
    rs(32'hC);
    ref_phase <= 9'd90;
    repeat (20) @(posedge pclk);
    rs(32'h10);
    apb(cfg, 1'b1, 32'h32);
    apb(cmd, 1'b1, 32'h4);
    apb(cmd, 1'b1, 32'h2);
    rs(32'hF);
    apb(cmd, 1'b1, 32'h8);
    repeat (20) @(posedge pclk);
    rs(32'h10);
    chk(7, n_ts, "starts");
    chk(7, n_to, "trigger out");
    chk(6, n_rg, "repeats");
    chk(2, n_aa, "acq aborts");
    apb(8'h10, 1'b0, 32'h0);
    chk(1, er, "slverr");
    chk(0, rd, "unmapped");
    $display("test measure done");
    for (i = 0; i < 8; i = i + 1)
    begin
      v = (i == 0) ? 361 : (i == 1) ? -361 : $random(seed) % 400;
      apb(phs, 1'b1, v);
      apb(phs, 1'b0, 32'h0);
      chk(clampf(v), rd, "phase");
    end
    $display("test phase range done");
    print_verdict;
  end
endmodule
